// >>> logic/tkc_core.sv
// Summary of operation
// (R01) digits shift in right, leading zeros dropped
// (R02) number after prefix key selects a register
// (R03) double zero key appends two zeros
// (R04) erase key leaves entry, cancels pending keys
// (R05) erased entry leaves target register unchanged
// (R06) erase held plus selector clears register
// (R07) selectors: time, lead, tail, master, source, offset
// (R08) time fetch shows selected machine live code
// (R09) cue position is in point minus lead
// (R10) lead-in register resets to five seconds
// (R11) tail-out five seconds, end is out plus tail
// (R12) offset is source align minus master align
// (R13) master align change recomputes all active offsets
// (R14) source align save or nudge recomputes its own offset
// (R15) offsets signed, magnitude at most twelve hours; an offset saved from the entry or display is stored without this limit
// (R16) one offset per source, none for master
// (R17) offset fetch on master reads zero
// (R18) offset is slave code minus master code
// (R19) offsets are delivered to slave machines only
// (R20) align and offset support save, fetch, nudge
// (R21) grab then offset key stores machine offset
// (R22) time held as fields, differences wrap daily
// (R23) clear zeroes register, deactivates source align
`timescale 1ns/100ps
`default_nettype none
`include "tkc_defs.svh"

module tkc_core #(
  parameter int NSRC = 6,
  parameter int MW   = 3
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              keyValid,
  input  wire tkc_pkg::tkc_key_t keyCode,
  input  wire logic              eraseHeld,
  input  wire logic [MW-1:0]     machSel,
  input  wire logic [MW-1:0]     masterMach,
  input  wire tkc_pkg::tkc_tc_t  curTc,
  input  wire tkc_pkg::tkc_tc_t  masterTc,
  input  wire tkc_pkg::tkc_tc_t  inPoint,
  input  wire tkc_pkg::tkc_tc_t  outPoint,
  output var  tkc_pkg::tkc_ofs_t dispVal,
  output var  logic              calcActive,
  output var  logic              busy,
  output var  tkc_pkg::tkc_tc_t  cuePos,
  output var  tkc_pkg::tkc_tc_t  endPos,
  output var  tkc_pkg::tkc_tc_t  leadIn,
  output var  tkc_pkg::tkc_tc_t  tailOut,
  output var  logic              timeLoad,
  output var  logic [MW-1:0]     timeLoadMach,
  output var  tkc_pkg::tkc_tc_t  timeLoadTc,
  output var  logic              ofsValid,
  output var  logic [MW-1:0]     ofsMach,
  output var  tkc_pkg::tkc_ofs_t ofsOut
);
  import tkc_pkg::*;

  typedef struct packed {
    tkc_st_t       st;
    tkc_act_t      act;
    tkc_pfx_t      pfx;
    logic [31:0]   ent;
    logic          entNeg;
    logic          calc;
    logic          live;
    logic          nudgeOn;
    logic [3:0]    nudgeSel;
    logic          nudgeDn;
    tkc_tc_t       lead;
    tkc_tc_t       tail;
    tkc_tc_t       mAlign;
    tkc_tc_t       capt;
    tkc_ofs_t      disp;
    logic [MW-1:0] idx;
    logic [MW-1:0] rdAddr;
    logic [MW-1:0] wrAddr;
    logic          alnWe;
    tkc_src_t      alnWr;
    logic          ofsWe;
    tkc_ofs_t      ofsWr;
    tkc_tc_t       cue;
    tkc_tc_t       endp;
    logic          tLoad;
    logic [MW-1:0] tLoadMach;
    tkc_tc_t       tLoadTc;
    logic          ofsV;
    logic          busy;
  } tkc_state_t;

  localparam tkc_tc_t ONE_FR = '{hr: 5'h00, mn: 6'h00, sc: 6'h00, fr: 5'h01};
  localparam tkc_tc_t ZERO_TC = '0;

  tkc_state_t s_q;
  tkc_state_t s_d;
  tkc_src_t   alnRd;
  tkc_ofs_t   ofsRd;

  function automatic logic [21:0] tc2fr(tkc_tc_t t);
    tc2fr = 22'(((t.hr * 60 + t.mn) * 60 + t.sc) * `TKC_FPS + t.fr);
  endfunction

  function automatic tkc_tc_t fr2tc(logic [21:0] f);
    logic [21:0] s;
    fr2tc.fr = 5'(f % `TKC_FPS);
    s = 22'(f / `TKC_FPS);
    fr2tc.sc = 6'(s % 60);
    s = 22'(s / 60);
    fr2tc.mn = 6'(s % 60);
    fr2tc.hr = 5'(s / 60);
  endfunction

  // a plus or minus b, wrapped into one day
  function automatic tkc_tc_t addMod(tkc_tc_t a, tkc_tc_t b, logic sub);
    logic [22:0] r;
    r = sub ? {1'b0, tc2fr(a)} + `TKC_DAY_FR - {1'b0, tc2fr(b)}
            : {1'b0, tc2fr(a)} + {1'b0, tc2fr(b)};
    if (r >= `TKC_DAY_FR) begin
      r = r - `TKC_DAY_FR;
    end
    addMod = fr2tc(r[21:0]);
  endfunction

  // signed a minus b: wrap modulo a day, then fold the upper half negative
  function automatic tkc_ofs_t signedDiff(tkc_tc_t a, tkc_tc_t b);
    logic [22:0] d;
    d = {1'b0, tc2fr(addMod(a, b, 1'b1))};   // [R22]
    if (d > `TKC_HALF_FR) begin
      signedDiff.neg = 1'b1;                 // [R15]
      signedDiff.tc  = fr2tc(22'(`TKC_DAY_FR - d));
    end else begin
      signedDiff.neg = 1'b0;
      signedDiff.tc  = fr2tc(d[21:0]);
    end
  endfunction

  // one-frame step of a signed offset, held within twelve hours
  function automatic tkc_ofs_t ofsStep(tkc_ofs_t o, logic dn);
    logic signed [23:0] v;
    logic [23:0]        m;
    m = {2'b00, tc2fr(o.tc)};
    v = o.neg ? -$signed(m) : $signed(m);
    v = dn ? v - 24'sd1 : v + 24'sd1;
    m = v[23] ? 24'(-v) : 24'(v);
    if (m > {1'b0, `TKC_HALF_FR}) begin
      ofsStep = o;                           // [R15]
    end else begin
      ofsStep.neg = v[23];
      ofsStep.tc  = fr2tc(m[21:0]);
    end
  endfunction

  // eight typed digits are HH MM SS FF
  function automatic tkc_tc_t ent2tc(logic [31:0] e);
    ent2tc.hr = 5'(e[31:28] * 10 + e[27:24]);
    ent2tc.mn = 6'(e[23:20] * 10 + e[19:16]);
    ent2tc.sc = 6'(e[15:12] * 10 + e[11:8]);
    ent2tc.fr = 5'(e[7:4] * 10 + e[3:0]);
  endfunction

  always_comb begin
    logic [4:0] kc;
    logic [3:0] sel;
    logic       isDig;
    logic       onMaster;
    tkc_tc_t    v;
    tkc_tc_t    nv;
    kc       = 5'(keyCode);
    sel      = kc[3:0];
    isDig    = kc < 5'h0a;
    onMaster = machSel == masterMach;
    v        = '0;
    nv       = '0;
    s_d      = s_q;
    s_d.alnWe = 1'b0;
    s_d.ofsWe = 1'b0;
    s_d.tLoad = 1'b0;
    s_d.ofsV  = 1'b0;
    s_d.cue   = addMod(inPoint, s_q.lead, 1'b1);     // [R09]
    s_d.endp  = addMod(outPoint, s_q.tail, 1'b0);    // [R11]
    if (s_q.live) begin
      s_d.disp = '{neg: 1'b0, tc: curTc};            // [R08]
    end
    case (s_q.st)
      ST_IDLE: begin
        if (keyValid && eraseHeld && isDig && sel <= `TKC_SEL_OFS) begin
          s_d.pfx = PFX_NONE;                        // [R06]
          if (sel == `TKC_SEL_LEAD) begin
            s_d.lead = ZERO_TC;                      // [R23]
          end else if (sel == `TKC_SEL_TAIL) begin
            s_d.tail = ZERO_TC;
          end else if (sel == `TKC_SEL_MAL) begin
            s_d.mAlign = ZERO_TC;
            s_d.idx    = '0;
            s_d.rdAddr = '0;
            s_d.act    = ACT_SWEEP;
            s_d.st     = ST_WAIT;                    // [R13]
          end else if (sel == `TKC_SEL_SRC && !onMaster) begin
            s_d.alnWe  = 1'b1;                       // [R23]
            s_d.alnWr  = '0;
            s_d.wrAddr = machSel;
          end else if (sel == `TKC_SEL_OFS && !onMaster) begin
            s_d.ofsWe  = 1'b1;
            s_d.ofsWr  = '0;
            s_d.wrAddr = machSel;
            s_d.ofsV   = 1'b1;
          end
        end else if (keyValid && keyCode == KEY_ERASE) begin
          s_d.calc    = 1'b0;                        // [R04]
          s_d.ent     = '0;                          // [R05]
          s_d.entNeg  = 1'b0;
          s_d.pfx     = PFX_NONE;
          s_d.nudgeOn = 1'b0;
          s_d.live    = 1'b1;
        end else if (keyValid && isDig && s_q.pfx != PFX_NONE) begin
          s_d.pfx = PFX_NONE;                        // [R02]
          v = s_q.calc ? ent2tc(s_q.ent)
                       : (s_q.pfx == PFX_GRAB ? s_q.capt : s_q.disp.tc);
          if (s_q.pfx == PFX_SAVE || s_q.pfx == PFX_GRAB) begin
            s_d.calc   = 1'b0;
            s_d.ent    = '0;
            s_d.entNeg = 1'b0;
            s_d.live   = 1'b1;
            if (sel == `TKC_SEL_TIME) begin          // [R07]
              s_d.tLoad     = 1'b1;
              s_d.tLoadMach = machSel;
              s_d.tLoadTc   = v;
            end else if (sel == `TKC_SEL_LEAD) begin
              s_d.lead = v;
            end else if (sel == `TKC_SEL_TAIL) begin
              s_d.tail = v;
            end else if (sel == `TKC_SEL_MAL) begin
              s_d.mAlign = v;
              s_d.idx    = '0;
              s_d.rdAddr = '0;
              s_d.act    = ACT_SWEEP;
              s_d.st     = ST_WAIT;                  // [R13]
            end else if (sel == `TKC_SEL_SRC && !onMaster) begin
              s_d.alnWe  = 1'b1;                     // [R20]
              s_d.alnWr  = '{active: 1'b1, tc: v};
              s_d.wrAddr = machSel;
              s_d.ofsWe  = 1'b1;                     // [R14]
              s_d.ofsWr  = signedDiff(v, s_q.mAlign); // [R12]
              s_d.ofsV   = 1'b1;
            end else if (sel == `TKC_SEL_OFS && !onMaster) begin
              s_d.ofsWe  = 1'b1;                     // [R16]
              s_d.wrAddr = machSel;
              s_d.ofsV   = 1'b1;
              if (s_q.pfx == PFX_GRAB) begin
                s_d.ofsWr = signedDiff(s_q.capt, masterTc); // [R21] [R18]
              end else begin
                s_d.ofsWr = '{neg: s_q.calc ? s_q.entNeg : s_q.disp.neg, tc: v};
              end
            end
          end else if (s_q.pfx == PFX_FETCH) begin
            s_d.calc = 1'b0;
            s_d.ent  = '0;
            s_d.live = sel == `TKC_SEL_TIME;         // [R08]
            if (sel == `TKC_SEL_LEAD) begin
              s_d.disp = '{neg: 1'b0, tc: s_q.lead};
            end else if (sel == `TKC_SEL_TAIL) begin
              s_d.disp = '{neg: 1'b0, tc: s_q.tail};
            end else if (sel == `TKC_SEL_MAL) begin
              s_d.disp = '{neg: 1'b0, tc: s_q.mAlign};
            end else if ((sel == `TKC_SEL_SRC || sel == `TKC_SEL_OFS) && onMaster) begin
              s_d.disp = '0;                         // [R17]
            end else if (sel == `TKC_SEL_SRC || sel == `TKC_SEL_OFS) begin
              s_d.rdAddr = machSel;                  // [R20]
              s_d.act    = sel == `TKC_SEL_SRC ? ACT_FETCH_SRC : ACT_FETCH_OFS;
              s_d.st     = ST_WAIT;
            end
          end else begin
            s_d.nudgeOn  = sel <= `TKC_SEL_OFS;
            s_d.nudgeSel = sel;
          end
        end else if (keyValid && isDig) begin
          s_d.nudgeOn = 1'b0;
          if (s_q.ent != '0 || sel != 4'h0) begin
            s_d.calc = 1'b1;
            s_d.live = 1'b0;
            s_d.ent  = {s_q.ent[27:0], sel};         // [R01]
            s_d.disp = '{neg: s_q.entNeg, tc: ent2tc(s_d.ent)};
          end
        end else if (keyValid && keyCode == KEY_DZERO) begin
          s_d.nudgeOn = 1'b0;
          if (s_q.ent != '0) begin
            s_d.calc = 1'b1;
            s_d.live = 1'b0;
            s_d.ent  = {s_q.ent[23:0], 8'h00};       // [R03]
            s_d.disp = '{neg: s_q.entNeg, tc: ent2tc(s_d.ent)};
          end
        end else if (keyValid && (keyCode == KEY_PLUS || keyCode == KEY_MINUS)) begin
          if (s_q.nudgeOn) begin
            s_d.nudgeDn = keyCode == KEY_MINUS;
            if (s_q.nudgeSel == `TKC_SEL_LEAD) begin
              s_d.lead = addMod(s_q.lead, ONE_FR, s_d.nudgeDn);
            end else if (s_q.nudgeSel == `TKC_SEL_TAIL) begin
              s_d.tail = addMod(s_q.tail, ONE_FR, s_d.nudgeDn);
            end else if (s_q.nudgeSel == `TKC_SEL_MAL) begin
              s_d.mAlign = addMod(s_q.mAlign, ONE_FR, s_d.nudgeDn);
              s_d.idx    = '0;
              s_d.rdAddr = '0;
              s_d.act    = ACT_SWEEP;
              s_d.st     = ST_WAIT;                  // [R13]
            end else if (s_q.nudgeSel >= `TKC_SEL_SRC && !onMaster) begin
              s_d.rdAddr = machSel;                  // [R20]
              s_d.act    = s_q.nudgeSel == `TKC_SEL_SRC ? ACT_NUDGE_SRC
                                                       : ACT_NUDGE_OFS;
              s_d.st     = ST_WAIT;
            end
          end else if (s_q.calc) begin
            s_d.entNeg   = keyCode == KEY_MINUS;
            s_d.disp.neg = s_d.entNeg;
          end
        end else if (keyValid) begin
          s_d.nudgeOn = 1'b0;
          case (keyCode)
            KEY_NUDGE: s_d.pfx = PFX_NUDGE;
            KEY_FETCH: s_d.pfx = PFX_FETCH;
            KEY_SAVE:  s_d.pfx = PFX_SAVE;
            default: begin
              s_d.pfx  = PFX_GRAB;
              s_d.capt = curTc;
            end
          endcase
        end
      end
      ST_WAIT: begin
        s_d.st = ST_USE;
      end
      default: begin
        s_d.st     = ST_IDLE;
        s_d.wrAddr = s_q.rdAddr;
        case (s_q.act)
          ACT_FETCH_SRC: begin
            s_d.disp = '{neg: 1'b0, tc: alnRd.tc};
            s_d.live = 1'b0;
          end
          ACT_FETCH_OFS: begin
            s_d.disp = ofsRd;
            s_d.live = 1'b0;
          end
          ACT_NUDGE_SRC: begin
            nv        = addMod(alnRd.tc, ONE_FR, s_q.nudgeDn);
            s_d.alnWe = 1'b1;
            s_d.alnWr = '{active: 1'b1, tc: nv};
            s_d.ofsWe = 1'b1;                        // [R14]
            s_d.ofsWr = signedDiff(nv, s_q.mAlign);
            s_d.ofsV  = 1'b1;
          end
          ACT_NUDGE_OFS: begin
            s_d.ofsWe = 1'b1;
            s_d.ofsWr = ofsStep(ofsRd, s_q.nudgeDn);
            s_d.ofsV  = 1'b1;
          end
          default: begin
            // the sweep walks every source; the master never gets one
            if (s_q.rdAddr != masterMach && alnRd.active) begin
              s_d.ofsWe = 1'b1;                      // [R13] [R16]
              s_d.ofsWr = signedDiff(alnRd.tc, s_q.mAlign);
              s_d.ofsV  = 1'b1;
            end
            if (32'(s_q.idx) < NSRC - 1) begin
              s_d.idx    = s_q.idx + 1'b1;
              s_d.rdAddr = s_q.idx + 1'b1;
              s_d.st     = ST_WAIT;
            end
          end
        endcase
      end
    endcase
    s_d.busy = s_d.st != ST_IDLE;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q           <= '0;
      s_q.live      <= 1'b1;
      s_q.lead.sc   <= `TKC_ROLL_SEC;              // [R10]
      s_q.tail.sc   <= `TKC_ROLL_SEC;              // [R11]
    end else begin
      s_q <= s_d;
    end
  end

  tkc_srcmem #(.DEPTH(NSRC), .WIDTH($bits(tkc_src_t)), .AW(MW)) alignMem (
    .mclk   (mclk),
    .resetn (resetn),
    .wrEn   (s_q.alnWe),
    .wrAddr (s_q.wrAddr),
    .wrData (s_q.alnWr),
    .rdAddr (s_q.rdAddr),
    .rdData (alnRd)
  );

  tkc_srcmem #(.DEPTH(NSRC), .WIDTH($bits(tkc_ofs_t)), .AW(MW)) offsetMem (
    .mclk   (mclk),
    .resetn (resetn),
    .wrEn   (s_q.ofsWe),
    .wrAddr (s_q.wrAddr),
    .wrData (s_q.ofsWr),
    .rdAddr (s_q.rdAddr),
    .rdData (ofsRd)
  );

  // every offset write is also sent to that slave synchronizer
  assign ofsValid     = s_q.ofsV;                  // [R19]
  assign ofsMach      = s_q.wrAddr;
  assign ofsOut       = s_q.ofsWr;
  assign dispVal      = s_q.disp;
  assign calcActive   = s_q.calc;
  assign busy         = s_q.busy;
  assign cuePos       = s_q.cue;
  assign endPos       = s_q.endp;
  assign leadIn       = s_q.lead;
  assign tailOut      = s_q.tail;
  assign timeLoad     = s_q.tLoad;
  assign timeLoadMach = s_q.tLoadMach;
  assign timeLoadTc   = s_q.tLoadTc;

endmodule

`default_nettype wire

// >>> logic/tkc_defs.svh
`ifndef TKC_DEFS_SVH
`define TKC_DEFS_SVH

// frame rate of the reference code, frames per second
`define TKC_FPS       23'h00_001e
// frames in one day of time code (24 h at TKC_FPS)
`define TKC_DAY_FR    23'h27_8d00
// frames in twelve hours, the largest offset magnitude
`define TKC_HALF_FR   23'h13_c680
// lead-in and tail-out default: five seconds
`define TKC_ROLL_SEC  6'h05

// register selector codes carried by numbered keys after a prefix
`define TKC_SEL_TIME  4'h0
`define TKC_SEL_LEAD  4'h1
`define TKC_SEL_TAIL  4'h2
`define TKC_SEL_MAL   4'h3
`define TKC_SEL_SRC   4'h4
`define TKC_SEL_OFS   4'h5

`endif

// >>> logic/tkc_pkg.sv
package tkc_pkg;

  typedef struct packed {
    logic [4:0] hr;
    logic [5:0] mn;
    logic [5:0] sc;
    logic [4:0] fr;
  } tkc_tc_t;

  // signed time code: sign plus magnitude
  typedef struct packed {
    logic    neg;
    tkc_tc_t tc;
  } tkc_ofs_t;

  typedef struct packed {
    logic    active;
    tkc_tc_t tc;
  } tkc_src_t;

  typedef enum logic [4:0] {
    KEY_D0    = 5'h00, KEY_D1    = 5'h01, KEY_D2   = 5'h02,
    KEY_D3    = 5'h03, KEY_D4    = 5'h04, KEY_D5   = 5'h05,
    KEY_D6    = 5'h06, KEY_D7    = 5'h07, KEY_D8   = 5'h08,
    KEY_D9    = 5'h09, KEY_DZERO = 5'h0a, KEY_ERASE = 5'h0b,
    KEY_NUDGE = 5'h0c, KEY_GRAB  = 5'h0d, KEY_FETCH = 5'h0e,
    KEY_SAVE  = 5'h0f, KEY_PLUS  = 5'h10, KEY_MINUS = 5'h11
  } tkc_key_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_USE  = 2'b10
  } tkc_st_t;

  typedef enum logic [2:0] {
    PFX_NONE  = 3'b000,
    PFX_NUDGE = 3'b001,
    PFX_GRAB  = 3'b010,
    PFX_FETCH = 3'b011,
    PFX_SAVE  = 3'b100
  } tkc_pfx_t;

  typedef enum logic [2:0] {
    ACT_FETCH_SRC = 3'b000,
    ACT_FETCH_OFS = 3'b001,
    ACT_NUDGE_SRC = 3'b010,
    ACT_NUDGE_OFS = 3'b011,
    ACT_SWEEP     = 3'b100
  } tkc_act_t;

endpackage

// >>> logic/tkc_srcmem.sv
`timescale 1ns/100ps
`default_nettype none

// small per-source store; read data is registered, one cycle latency
module tkc_srcmem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 23,
  parameter int AW    = 3
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output var  logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // cleared at reset so no entry starts out marked active
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rdData <= '0;
    end else begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end

endmodule

`default_nettype wire

// >>> dv/tkc_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "tkc_defs.svh"

module tkc_core_properties #(
  parameter int NSRC = 6,
  parameter int MW   = 3
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              keyValid,
  input wire tkc_pkg::tkc_key_t keyCode,
  input wire logic              eraseHeld,
  input wire logic [MW-1:0]     masterMach,
  input wire tkc_pkg::tkc_tc_t  inPoint,
  input wire tkc_pkg::tkc_ofs_t dispVal,
  input wire logic              calcActive,
  input wire logic              busy,
  input wire tkc_pkg::tkc_tc_t  cuePos,
  input wire tkc_pkg::tkc_tc_t  leadIn,
  input wire logic              ofsValid,
  input wire logic [MW-1:0]     ofsMach,
  input wire tkc_pkg::tkc_ofs_t ofsOut
);
  import tkc_pkg::*;
  localparam int DAY  = `TKC_DAY_FR;
  localparam int HALF = `TKC_HALF_FR;
  tkc_key_t key_q;
  logic     nudge_q;
  logic     sweep_q;
  int       busyCnt;
  logic     took;
  logic     pfx;
  logic     plain;

  function automatic int fr(tkc_tc_t t);
    return t.hr * 108000 + t.mn * 1800 + t.sc * 30 + t.fr;
  endfunction

  assign took  = keyValid && !busy;
  assign pfx   = key_q inside {KEY_NUDGE, KEY_GRAB, KEY_FETCH, KEY_SAVE};
  assign plain = took && !pfx && !eraseHeld;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      key_q   <= KEY_D0;
      nudge_q <= 1'b0;
      sweep_q <= 1'b0;
      busyCnt <= 0;
    end else begin
      if (took) begin
        key_q   <= keyCode;
        nudge_q <= keyCode inside {KEY_PLUS, KEY_MINUS} ? nudge_q
                   : key_q == KEY_NUDGE && keyCode == KEY_D3;
        sweep_q <= keyCode == KEY_D3 && (eraseHeld || key_q inside {KEY_SAVE, KEY_GRAB})
                   || nudge_q && keyCode inside {KEY_PLUS, KEY_MINUS};
      end
      busyCnt <= busy ? busyCnt + 1 : 0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  cue_calc_a: assert property (
    resetn |=> fr(cuePos) == (fr($past(inPoint)) - fr($past(leadIn)) + DAY) % DAY)
    else $error("cue position wrong");
  lead_hold_a: assert property (!$stable(leadIn) |-> $past(took))
    else $error("lead-in changed without a key");
  erase_leave_a: assert property (took && keyCode == KEY_ERASE |=> !calcActive)
    else $error("erase left entry active");
  digit_shift_a: assert property (
    plain && !calcActive && keyCode inside {[KEY_D1:KEY_D9]}
    |=> calcActive && dispVal == {18'h0_0000, $past(keyCode)})
    else $error("first digit not in lowest place");
  zero_drop_a: assert property (
    plain && !calcActive && keyCode inside {KEY_D0, KEY_DZERO} |=> !calcActive)
    else $error("leading zero started entry");
  ofs_range_a: assert property (
    ofsValid |-> fr(ofsOut.tc) < HALF || (fr(ofsOut.tc) == HALF && !ofsOut.neg))
    else $error("offset beyond twelve hours");
  slave_only_a: assert property (ofsValid |-> ofsMach != masterMach && ofsMach < NSRC)
    else $error("offset sent to master");
  sweep_len_a: assert property ($fell(busy) |-> busyCnt == (sweep_q ? 2 * NSRC : 2))
    else $error("sweep length wrong");
endmodule

bind tkc_core tkc_core_properties #(.NSRC(NSRC), .MW(MW)) uProps (
  .mclk(mclk), .resetn(resetn), .keyValid(keyValid), .keyCode(keyCode),
  .eraseHeld(eraseHeld), .masterMach(masterMach), .inPoint(inPoint), .dispVal(dispVal),
  .calcActive(calcActive), .busy(busy), .cuePos(cuePos), .leadIn(leadIn),
  .ofsValid(ofsValid), .ofsMach(ofsMach), .ofsOut(ofsOut)
);
`default_nettype wire

// >>> dv/tkc_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// stationary transports plus the synchronizer modules that take offsets
module tkc_far_model #(
  parameter int MW = 3
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic [MW-1:0]     machSel,
  input wire logic [MW-1:0]     masterMach,
  input wire logic              ofsValid,
  input wire logic [MW-1:0]     ofsMach,
  input wire tkc_pkg::tkc_ofs_t ofsOut,
  output var tkc_pkg::tkc_tc_t  curTc,
  output var tkc_pkg::tkc_tc_t  masterTc
);
  import tkc_pkg::*;
  tkc_tc_t  liveTc [1<<MW];
  tkc_ofs_t ofsGot [1<<MW];
  int       nRx    [1<<MW];

  assign curTc    = liveTc[machSel];
  assign masterTc = liveTc[masterMach];

  // each module keeps only its own offset; deliveries are counted per machine
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      foreach (nRx[i]) nRx[i] <= 0;
    end else if (ofsValid) begin
      ofsGot[ofsMach] <= ofsOut;
      nRx[ofsMach]    <= nRx[ofsMach] + 1;
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb_timecode_keypad_calculator.sv
`timescale 1ns/100ps
`default_nettype none
`include "tkc_defs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module tb_timecode_keypad_calculator;
  import tkc_pkg::*;
  localparam int      DAY  = `TKC_DAY_FR;
  localparam int      HALF = `TKC_HALF_FR;
  localparam tkc_tc_t FIVE = '{5'h0, 6'h0, `TKC_ROLL_SEC, 5'h0};
  logic       mclk       = 1'b0;
  logic       resetn     = 1'b0;
  logic       keyValid   = 1'b0;
  tkc_key_t   keyCode    = KEY_D0;
  logic       eraseHeld  = 1'b0;
  logic [2:0] machSel    = 3'h0;
  logic [2:0] masterMach = 3'h0;
  tkc_tc_t    inPoint    = '0;
  tkc_tc_t    outPoint   = '0;
  tkc_tc_t    curTc, masterTc, cuePos, endPos, leadIn, tailOut, v, mAl;
  tkc_tc_t    srcAl [8];
  tkc_ofs_t   dispVal, ofsOut;
  logic       calcActive, busy, ofsValid;
  logic [2:0] ofsMach;
  int         n_errors   = 0;
  int         num_checks = 0;
  int         n;
  integer     seed       = 32'hee28_e1df;

  always #4 mclk = ~mclk;

  tkc_core #(.NSRC(6), .MW(3)) DUT (
    .mclk(mclk), .resetn(resetn), .keyValid(keyValid), .keyCode(keyCode),
    .eraseHeld(eraseHeld), .machSel(machSel), .masterMach(masterMach), .curTc(curTc),
    .masterTc(masterTc), .inPoint(inPoint), .outPoint(outPoint), .dispVal(dispVal),
    .calcActive(calcActive), .busy(busy), .cuePos(cuePos), .endPos(endPos),
    .leadIn(leadIn), .tailOut(tailOut), .timeLoad(), .timeLoadMach(), .timeLoadTc(),
    .ofsValid(ofsValid), .ofsMach(ofsMach), .ofsOut(ofsOut)
  );
  tkc_far_model #(.MW(3)) far (
    .mclk(mclk), .resetn(resetn), .machSel(machSel), .masterMach(masterMach),
    .ofsValid(ofsValid), .ofsMach(ofsMach), .ofsOut(ofsOut), .curTc(curTc),
    .masterTc(masterTc)
  );

  function automatic int fr(tkc_tc_t t);
    return t.hr * 108000 + t.mn * 1800 + t.sc * 30 + t.fr;
  endfunction
  function automatic tkc_tc_t tcOf(int f);
    return '{5'(f / 108000), 6'(f / 1800 % 60), 6'(f / 30 % 60), 5'(f % 30)};
  endfunction
  function automatic tkc_ofs_t ofsOf(tkc_tc_t s, tkc_tc_t m);
    int d;
    d = (fr(s) - fr(m) + DAY) % DAY;
    return (d > HALF) ? {1'b1, tcOf(DAY - d)} : {1'b0, tcOf(d)};
  endfunction
  function automatic tkc_tc_t rtc(int lim);
    return tcOf($unsigned($random(seed)) % lim);
  endfunction

  task automatic settle();
    repeat (6) @(negedge mclk);
  endtask
  task automatic key(tkc_key_t k);
    int w;
    @(posedge mclk);
    keyValid <= 1'b1;
    keyCode  <= k;
    @(posedge mclk);
    keyValid <= 1'b0;
    @(negedge mclk);
    for (w = 0; w < 40 && busy !== 1'b0; w++) @(negedge mclk);
    if (busy !== 1'b0) n_errors++;
  endtask
  task automatic op(tkc_key_t p, tkc_key_t s);
    key(p);
    key(s);
    settle();
  endtask
  task automatic typeTc(tkc_tc_t t);
    int d [8];
    d = '{t.hr / 10, t.hr % 10, t.mn / 10, t.mn % 10, t.sc / 10, t.sc % 10, t.fr / 10, t.fr % 10};
    foreach (d[i]) key(tkc_key_t'(d[i]));
  endtask
  task automatic setm(logic [2:0] m);
    @(posedge mclk);
    machSel <= m;
    settle();
  endtask
  task automatic chkAll(int lo);
    for (int m = lo; m < 4; m++) begin
      `CHK(far.ofsGot[m], ofsOf(srcAl[m], mAl));
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 8; i++) far.liveTc[i] = rtc(DAY);
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    `CHK(leadIn, FIVE);
    `CHK(tailOut, FIVE);
    key(KEY_D0);
    key(KEY_DZERO);
    `CHK(calcActive, 1'b0);
    key(KEY_D1);
    key(KEY_D2);
    key(KEY_DZERO);
    `CHK(dispVal, {1'b0, tcOf(360)});
    key(KEY_ERASE);
    `CHK(calcActive, 1'b0);
    `CHK(leadIn, FIVE);
    repeat (3) begin
      v = rtc(DAY);
      typeTc(v);
      op(KEY_SAVE, KEY_D1);
      `CHK(leadIn, v);
      @(posedge mclk);
      inPoint  <= rtc(DAY);
      outPoint <= rtc(DAY);
      settle();
      `CHK(cuePos, tcOf((fr(inPoint) - fr(v) + DAY) % DAY));
      v = rtc(DAY);
      typeTc(v);
      op(KEY_SAVE, KEY_D2);
      `CHK(endPos, tcOf((fr(outPoint) + fr(v)) % DAY));
    end
    mAl = rtc(DAY);
    typeTc(mAl);
    op(KEY_SAVE, KEY_D3);
    for (int m = 1; m < 4; m++) begin
      setm(m);
      srcAl[m] = (m == 1) ? rtc(DAY) : tcOf((fr(mAl) + (m == 2 ? DAY - 1 : HALF)) % DAY);
      typeTc(srcAl[m]);
      op(KEY_SAVE, KEY_D4);
      `CHK(far.ofsGot[m], ofsOf(srcAl[m], mAl));
    end
    op(KEY_NUDGE, KEY_D3);
    key(KEY_PLUS);
    settle();
    key(KEY_ERASE);
    mAl = tcOf((fr(mAl) + 1) % DAY);
    chkAll(1);
    setm(1);
    @(posedge mclk);
    eraseHeld <= 1'b1;
    key(KEY_D4);
    @(posedge mclk);
    eraseHeld <= 1'b0;
    settle();
    n = far.nRx[1];
    mAl = rtc(DAY);
    typeTc(mAl);
    op(KEY_SAVE, KEY_D3);
    chkAll(2);
    `CHK(far.nRx[1], n);
    setm(0);
    op(KEY_FETCH, KEY_D5);
    `CHK(dispVal, 23'h00_0000);
    typeTc(rtc(HALF));
    op(KEY_SAVE, KEY_D5);
    key(KEY_ERASE);
    `CHK(far.nRx[0] + far.nRx[4] + far.nRx[5], 0);
    setm(2);
    op(KEY_FETCH, KEY_D5);
    `CHK(dispVal, ofsOf(srcAl[2], mAl));
    setm(3);
    op(KEY_FETCH, KEY_D0);
    `CHK(dispVal, {1'b0, far.liveTc[3]});
    setm(2);
    v = rtc(HALF);
    typeTc(v);
    op(KEY_SAVE, KEY_D5);
    `CHK(far.ofsGot[2], {1'b0, v});
    op(KEY_NUDGE, KEY_D5);
    key(KEY_PLUS);
    settle();
    `CHK(far.ofsGot[2], {1'b0, tcOf(fr(v) + 1)});
    key(KEY_ERASE);
    setm(3);
    op(KEY_GRAB, KEY_D5);
    `CHK(far.ofsGot[3], ofsOf(far.liveTc[3], far.liveTc[0]));
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
